// [hdma_arbiter.sv]
// Program memory and image memory arbiter between host, processor and timing sequencer.
//
// Summary of operation
// - Host control bit 6 low selects program memory, high selects image memory.
// - Hold request goes out only during a host program memory cycle.
// - Host program memory cycle is stretched with wait states until hold grant is seen.
// - Host path reaches program memory only under grant; hold drops at cycle end.
// - Memory space select bit 15 picks image memory, else sequencer memory.
// - Lowest 1K of processor data space reaches image memory only with offset.
// - Sequencer memory is reached at a 32K base, seen there as address zero.
// - One image memory owner at a time; video hands it to the sequencer.
// - Host owns image memory only with grant bit set and claim bit clear.
// - No signal tells the host that the processor holds image memory.
// - One DRAM row must be refreshed every 15.625 microseconds.
// - Image memory is 32 bits; reads fetch all, writes touch selected lanes.
// - Sequencer loads five refresh cycles at each horizontal blanking start and issues them during the blanking while video is active.
// - Host image memory accesses take no host wait states.
// - Address bits 15:14 add to the offset register; only the owner writes it.
// - Host refresh reaches DRAM only with vertical refresh enable set.
// - Byte mode returns read data on the low byte, upper byte zero.
// - Each processor image memory cycle has exactly one wait state.
`timescale 1ns/100ps
`default_nettype none
`include "hdma_defines.svh"

module hdma_arbiter import hdma_pkg::*; #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16,
    parameter int MOR_W  = 16
) (
    // Clock and reset.
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // Register bus.
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // Host memory window.
    input  wire logic                  host_cyc,
    input  wire logic                  host_wr,
    input  wire logic [ADDR_W-1:0]     host_addr,
    input  wire logic [DATA_W-1:0]     host_wdata,
    input  wire logic                  host_byte,
    input  wire logic                  host_refresh,
    output logic                       host_ready,
    output logic [DATA_W-1:0]          host_rdata,
    // Processor bus.
    output logic                       hold_req,
    input  wire logic                  bus_hold_grant,
    input  wire logic                  dsp_cyc,
    input  wire logic                  dsp_wr,
    input  wire logic [ADDR_W-1:0]     dsp_addr,
    input  wire logic [DATA_W-1:0]     dsp_wdata,
    output logic                       dsp_ready,
    output logic [DATA_W-1:0]          dsp_rdata,
    // Program memory.
    output logic                       pm_en,
    output logic                       pm_we,
    output logic [ADDR_W-2:0]          pm_addr,
    output logic [DATA_W-1:0]          pm_wdata,
    input  wire logic [DATA_W-1:0]     pm_rdata,
    // Timing sequencer memory.
    output logic                       seq_mem_en,
    output logic                       seq_mem_we,
    output logic [ADDR_W-2:0]          seq_mem_addr,
    output logic [DATA_W-1:0]          seq_mem_wdata,
    input  wire logic [DATA_W-1:0]     seq_mem_rdata,
    // Video timing.
    input  wire logic                  video_active,
    input  wire logic                  hblank,
    output logic                       seq_owns_im,
    // Image memory.
    output logic                       im_cyc,
    output logic                       im_we,
    output logic [3:0]                 im_be,
    output logic [MOR_W+ADDR_W-3:0]    im_addr,
    output logic [31:0]                im_wdata,
    output logic                       im_refresh,
    input  wire logic [31:0]           im_rdata
);

    localparam int IM_AW = MOR_W + ADDR_W - 2;

    // Lane enables for an access of one byte or one half word.
    function automatic logic [3:0] lanes(input logic [1:0] a, input logic byte_mode);
        logic [3:0] l;
        l = 4'h0;
        if (byte_mode) begin
            l[a] = 1'b1;
        end else begin
            l = a[1] ? 4'hc : 4'h3;
        end
        return l;
    endfunction

    // Read data picked out of a 32-bit word, zero above a byte.
    function automatic logic [15:0] pick(input logic [31:0] w, input logic [1:0] a,
                                         input logic byte_mode);
        logic [15:0] h;
        h = a[1] ? w[31:16] : w[15:0];
        return byte_mode ? {8'h00, (a[0] ? h[15:8] : h[7:0])} : h;
    endfunction

    logic [15:0]     host_control_reg_one;
    logic [15:0]     processor_control_reg_one;
    logic [15:0]     processor_arbitration_reg;
    logic [15:0]     processor_access_mode_reg;
    logic [MOR_W-1:0] memory_offset_register;
    logic [15:0]     vertical_control_register;
    logic            refresh_overdue;
    logic            ph_wr;
    logic [7:0]      ph_addr;
    hdma_pm_e        pm_state;
    hdma_pm_e        next_pm_state;
    logic [8:0]      row_cnt;
    logic [2:0]      burst_cnt;
    logic            hblank_d;
    logic            dsp_wait;

    // Bus decode.
    wire         bus_take   = hsel & htrans[1] & hready;
    wire [7:0]   rd_off     = haddr[7:0];
    wire         wr_host    = ph_wr & (ph_addr == `HDMA_OFF_HOST_CTRL);
    wire         wr_pctl    = ph_wr & (ph_addr == `HDMA_OFF_PROC_CTRL);
    wire         wr_parb    = ph_wr & (ph_addr == `HDMA_OFF_PROC_ARB);
    wire         wr_mode    = ph_wr & (ph_addr == `HDMA_OFF_PROC_MODE);
    wire         wr_mor_p   = ph_wr & (ph_addr == `HDMA_OFF_MOR_PROC);
    wire         wr_mor_h   = ph_wr & (ph_addr == `HDMA_OFF_MOR_HOST);
    wire         wr_vctl    = ph_wr & (ph_addr == `HDMA_OFF_VERT_CTRL);
    wire         wr_stat    = ph_wr & (ph_addr == `HDMA_OFF_STATUS);

    wire         host_sel_pm  = ~host_control_reg_one[`HDMA_BIT_WINDOW_SEL];
    wire         host_sel_im  = host_control_reg_one[`HDMA_BIT_WINDOW_SEL];

    wire         host_grant   = host_control_reg_one[`HDMA_BIT_HOST_GRANT] &
                                ~processor_arbitration_reg[`HDMA_BIT_PROC_CLAIM];
    hdma_owner_e owner;
    assign owner = video_active ? HDMA_OWN_SEQ :
                   (host_grant ? HDMA_OWN_HOST : HDMA_OWN_DSP);
    wire         own_host     = (owner == HDMA_OWN_HOST);
    wire         own_dsp      = (owner == HDMA_OWN_DSP);
    assign seq_owns_im = (owner == HDMA_OWN_SEQ);

    wire         dsp_space_im = processor_control_reg_one[`HDMA_BIT_SPACE_SEL];
    wire         byte_mode    = processor_access_mode_reg[`HDMA_BIT_BYTE_MODE];
    wire         dsp_onchip   = (dsp_addr < `HDMA_ONCHIP_LIMIT) &&
                                (memory_offset_register == '0);
    wire         dsp_im_cyc   = dsp_cyc & dsp_space_im & own_dsp & ~dsp_onchip;
    wire         dsp_seq_cyc  = dsp_cyc & ~dsp_space_im;
    wire         host_pm_cyc  = host_cyc & host_sel_pm;
    wire         host_im_cyc  = host_cyc & host_sel_im & own_host;

    wire [ADDR_W-1:0]  im_src    = own_host ? host_addr : dsp_addr;
    wire [MOR_W-1:0]   win_sum   = memory_offset_register +
                                   {{(MOR_W-2){1'b0}}, im_src[ADDR_W-1:ADDR_W-2]};
    wire [IM_AW-1:0]   next_im_a = {win_sum, im_src[ADDR_W-3:0]};

    wire         acc_byte  = own_host ? host_byte : byte_mode;
    wire [3:0]   next_be   = lanes(im_src[1:0], acc_byte);
    wire [15:0]  acc_wdata = own_host ? host_wdata : dsp_wdata;

    wire         row_tick  = (row_cnt == 9'(`HDMA_ROW_CYCLES - 1));
    wire         seq_ref   = seq_owns_im & hblank & (burst_cnt != 3'h0);
    wire         host_ref  = host_refresh & own_host &
                             vertical_control_register[`HDMA_BIT_VREF_EN];
    wire         next_ref  = seq_ref | host_ref;
    wire         im_go     = (host_im_cyc | (dsp_im_cyc & ~dsp_wait)) & ~next_ref;

    // Register read mux.
    // no owner flag
    wire [15:0]  status = {12'h000, refresh_overdue, video_active,
                           bus_hold_grant, hold_req};
    wire [31:0]  rd_word =
        (rd_off == `HDMA_OFF_HOST_CTRL) ? {16'h0000, host_control_reg_one} :
        (rd_off == `HDMA_OFF_PROC_CTRL) ? {16'h0000, processor_control_reg_one} :
        (rd_off == `HDMA_OFF_PROC_ARB)  ? {16'h0000, processor_arbitration_reg} :
        (rd_off == `HDMA_OFF_PROC_MODE) ? {16'h0000, processor_access_mode_reg} :
        ((rd_off == `HDMA_OFF_MOR_PROC) || (rd_off == `HDMA_OFF_MOR_HOST)) ?
                                          32'(memory_offset_register) :
        (rd_off == `HDMA_OFF_VERT_CTRL) ? {16'h0000, vertical_control_register} :
        (rd_off == `HDMA_OFF_STATUS)    ? {16'h0000, status} : `HDMA_RST_WORD;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Bus slave phases and read data.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_addr <= 8'h00;
            hrdata  <= `HDMA_RST_WORD;
        end else begin
            ph_wr <= bus_take & hwrite;
            if (bus_take) begin
                ph_addr <= haddr[7:0];
                hrdata  <= hwrite ? `HDMA_RST_WORD : rd_word;
            end
        end
    end

    // Control registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_control_reg_one      <= `HDMA_RST_REG16;
            processor_control_reg_one <= `HDMA_RST_REG16;
            processor_arbitration_reg <= `HDMA_RST_REG16;
            processor_access_mode_reg <= `HDMA_RST_REG16;
            vertical_control_register <= `HDMA_RST_REG16;
            memory_offset_register    <= '0;
        end else begin
            if (wr_host) host_control_reg_one <= hwdata[15:0];
            if (wr_pctl) processor_control_reg_one <= hwdata[15:0];
            if (wr_parb) processor_arbitration_reg <= hwdata[15:0];
            if (wr_mode) processor_access_mode_reg <= hwdata[15:0];
            if (wr_vctl) vertical_control_register <= hwdata[15:0];
            if ((wr_mor_p && own_dsp) || (wr_mor_h && own_host)) begin
                memory_offset_register <= hwdata[MOR_W-1:0];
            end
        end
    end

    // Program memory hold sequence.
    always_comb begin
        next_pm_state = pm_state;
        unique case (pm_state)
            HDMA_PM_IDLE: if (host_pm_cyc) next_pm_state = HDMA_PM_WAIT;
            HDMA_PM_WAIT: begin
                if (!host_pm_cyc) next_pm_state = HDMA_PM_IDLE;
                else if (bus_hold_grant) next_pm_state = HDMA_PM_OPEN;
            end
            HDMA_PM_OPEN: if (!host_pm_cyc) next_pm_state = HDMA_PM_IDLE;
            default: next_pm_state = HDMA_PM_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pm_state <= HDMA_PM_IDLE;
        else pm_state <= next_pm_state;
    end

    assign hold_req   = host_pm_cyc & (pm_state != HDMA_PM_IDLE);
    wire   pm_path    = hold_req & bus_hold_grant;
    assign host_ready = ~host_pm_cyc | pm_path;

    assign seq_mem_en    = dsp_seq_cyc;
    assign seq_mem_we    = dsp_seq_cyc & dsp_wr;
    assign seq_mem_addr  = dsp_addr[ADDR_W-2:0];
    assign seq_mem_wdata = dsp_wdata;

    wire dsp_slow = dsp_im_cyc;
    assign dsp_ready = ~dsp_cyc | ~dsp_slow | (dsp_wait == 1'(`HDMA_DSP_WAIT_STATES));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) dsp_wait <= 1'b0;
        else dsp_wait <= dsp_slow & ~dsp_wait;
    end

    // Program memory and data return.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pm_en      <= 1'b0;
            pm_we      <= 1'b0;
            pm_addr    <= '0;
            pm_wdata   <= '0;
            host_rdata <= '0;
            dsp_rdata  <= '0;
        end else begin
            pm_en <= pm_path;
            pm_we <= pm_path & host_wr;
            if (pm_path) begin
                pm_addr  <= host_addr[ADDR_W-2:0];
                pm_wdata <= host_wdata;
            end
            if (host_pm_cyc && pm_path) host_rdata <= pm_rdata;
            if (host_im_cyc) host_rdata <= pick(im_rdata, host_addr[1:0], host_byte);
            if (dsp_im_cyc && dsp_wait) dsp_rdata <= pick(im_rdata, dsp_addr[1:0], byte_mode);
            if (dsp_seq_cyc) dsp_rdata <= seq_mem_rdata;
        end
    end

    // Image memory cycle outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            im_cyc     <= 1'b0;
            im_we      <= 1'b0;
            im_be      <= 4'h0;
            im_addr    <= '0;
            im_wdata   <= `HDMA_RST_WORD;
            im_refresh <= 1'b0;
        end else begin
            im_cyc     <= im_go;
            im_refresh <= next_ref;
            im_we      <= im_go & (own_host ? host_wr : dsp_wr);
            if (im_go) begin
                im_be    <= next_be;
                im_addr  <= next_im_a;
                im_wdata <= {acc_wdata, acc_wdata};
                if (acc_byte) im_wdata <= {4{acc_wdata[7:0]}};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hblank_d  <= 1'b0;
            burst_cnt <= 3'h0;
        end else begin
            hblank_d <= hblank;
            if (hblank && !hblank_d) burst_cnt <= 3'(`HDMA_HBLANK_REFRESH);
            else if (seq_ref) burst_cnt <= burst_cnt - 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            row_cnt         <= 9'h000;
            refresh_overdue <= 1'b0;
        end else begin
            row_cnt <= (row_tick || next_ref || (im_go && own_dsp)) ? 9'h000 : row_cnt + 9'h001;
            if (row_tick) refresh_overdue <= 1'b1;
            else if (wr_stat && hwdata[`HDMA_BIT_ST_OVERDUE]) refresh_overdue <= 1'b0;
        end
    end


endmodule
`default_nettype wire

// [hdma_arbiter_chk.sv]
// Assertion checker for the memory arbiter ports.
`timescale 1ns/100ps
`default_nettype none
module hdma_arbiter_chk #(
    parameter int ADDR_W = 16
) (
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Host and processor.
    input  wire logic              host_cyc,
    input  wire logic              host_ready,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic              hold_req,
    input  wire logic              bus_hold_grant,
    input  wire logic              dsp_ready,
    input  wire logic              dsp_cyc,
    input  wire logic [ADDR_W-1:0] dsp_addr,
    // Memories and video.
    input  wire logic              pm_en,
    input  wire logic [ADDR_W-2:0] pm_addr,
    input  wire logic              seq_mem_en,
    input  wire logic [ADDR_W-2:0] seq_mem_addr,
    input  wire logic              im_cyc,
    input  wire logic              im_we,
    input  wire logic              im_refresh,
    input  wire logic              video_active,
    input  wire logic              hblank,
    input  wire logic              seq_owns_im
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_hold_cause:
        assert property (hold_req |-> host_cyc) else $error("hold without cycle");
    a_hold_start:
        assert property ($rose(host_cyc) && !host_ready |=> hold_req) else $error("hold late");
    a_wait_grant:
        assert property (hold_req |-> host_ready == bus_hold_grant) else $error("wait wrong");
    a_pm_gate:
        assert property (pm_en |-> $past(hold_req) && $past(bus_hold_grant))
        else $error("program memory ungated");
    a_pm_addr:
        assert property (pm_en |-> pm_addr == $past(host_addr[ADDR_W-2:0]))
        else $error("program address wrong");
    a_dsp_wait:
        assert property (!dsp_ready |-> dsp_cyc ##1 dsp_ready && (im_cyc || im_refresh))
        else $error("processor wait wrong");
    a_video_lock:
        assert property (video_active && $past(video_active) |-> seq_owns_im && !im_cyc && !im_we)
        else $error("video lockout broken");
    a_refresh_burst:
        assert property ($rose(hblank) && video_active |-> ##[1:2] im_refresh [*5])
        else $error("refresh burst short");
    a_seq_base:
        assert property (seq_mem_en |-> dsp_cyc && seq_mem_addr == dsp_addr[ADDR_W-2:0])
        else $error("sequencer address wrong");
    c_granted: cover property (hold_req && bus_hold_grant);
    c_dsp_wait: cover property (!dsp_ready);
    c_refresh: cover property (im_refresh);
endmodule
bind hdma_arbiter hdma_arbiter_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// [hdma_defines.svh]
// Offsets, field positions, reset values and timing counts of the arbiter.
`ifndef HDMA_DEFINES_SVH
`define HDMA_DEFINES_SVH

`define HDMA_OFF_HOST_CTRL      8'h00
`define HDMA_OFF_PROC_CTRL      8'h04
`define HDMA_OFF_PROC_ARB       8'h08
`define HDMA_OFF_PROC_MODE      8'h0c
`define HDMA_OFF_MOR_PROC       8'h10
`define HDMA_OFF_MOR_HOST       8'h14
`define HDMA_OFF_VERT_CTRL      8'h18
`define HDMA_OFF_STATUS         8'h1c

`define HDMA_BIT_WINDOW_SEL     6
`define HDMA_BIT_HOST_GRANT     4
`define HDMA_BIT_SPACE_SEL      15
`define HDMA_BIT_PROC_CLAIM     4
`define HDMA_BIT_BYTE_MODE      0
`define HDMA_BIT_VREF_EN        0
`define HDMA_BIT_ST_HOLD        0
`define HDMA_BIT_ST_GRANT       1
`define HDMA_BIT_ST_VIDEO       2
`define HDMA_BIT_ST_OVERDUE     3

`define HDMA_RST_REG16          16'h0000
`define HDMA_RST_WORD           32'h0000_0000
`define HDMA_ONCHIP_LIMIT       16'h0400
`define HDMA_CLK_MHZ            25
`define HDMA_ROW_PERIOD_NS      15625
`define HDMA_ROW_CYCLES         ((`HDMA_ROW_PERIOD_NS * `HDMA_CLK_MHZ) / 1000)
`define HDMA_DSP_CYCLE_NS       160
`define HDMA_DSP_WAIT_STATES    1
`define HDMA_HBLANK_REFRESH     5

`endif

// [hdma_dsp_model.sv]
// Processor core model that answers bus hold and holds program memory.
`timescale 1ns/100ps
`default_nettype none
module hdma_dsp_model #(
    parameter int DELAY = 2
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Hold handshake.
    input  wire logic        hold_req,
    input  wire logic [7:0]  rpt_cycles,
    output logic             bus_hold_grant,
    // Program memory.
    input  wire logic        pm_en,
    input  wire logic        pm_we,
    input  wire logic [14:0] pm_addr,
    input  wire logic [15:0] pm_wdata,
    output logic [15:0]      pm_rdata
);
    logic [7:0]  cnt;
    logic [15:0] last;
    logic [15:0] mem [0:15];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt            <= 8'h00;
            bus_hold_grant <= 1'b0;
        end else begin
            cnt            <= hold_req ? cnt + 8'h01 : 8'h00;
            bus_hold_grant <= hold_req && (int'(cnt) >= DELAY + int'(rpt_cycles));
        end
    end

    always_ff @(posedge hclk) begin
        if (pm_en && pm_we) begin
            mem[pm_addr[3:0]] <= pm_wdata;
        end
        if (pm_en) begin
            last <= pm_rdata;
        end
    end
    assign pm_rdata = pm_en ? mem[pm_addr[3:0]] : ~last;
endmodule
`default_nettype wire

// [hdma_pkg.sv]
// Types shared by the host and processor memory arbiter.
package hdma_pkg;

    typedef enum logic [2:0] {
        HDMA_PM_IDLE  = 3'b001,
        HDMA_PM_WAIT  = 3'b010,
        HDMA_PM_OPEN  = 3'b100
    } hdma_pm_e;

    typedef enum logic [2:0] {
        HDMA_OWN_DSP  = 3'b001,
        HDMA_OWN_HOST = 3'b010,
        HDMA_OWN_SEQ  = 3'b100
    } hdma_owner_e;

endpackage

// [tb_host_dsp_memory_arbiter.sv]
// Self-checking bench for the host and processor memory arbiter.
`timescale 1ns/100ps
`default_nettype none
`include "hdma_defines.svh"
module tb_host_dsp_memory_arbiter;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        host_cyc = 1'b0, host_wr = 1'b0, host_byte = 1'b0, host_refresh = 1'b0;
    logic        dsp_cyc = 1'b0, dsp_wr = 1'b0, video_active = 1'b0, hblank = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, im_rdata = 32'h4433_2211;
    logic [15:0] host_addr = 16'h0, host_wdata = 16'h0, dsp_addr = 16'h0;
    logic [15:0] dsp_wdata = 16'h0, seq_mem_rdata = 16'h5a5a;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [7:0]  rpt_cycles = 8'h00;
    logic        hready, hreadyout, hresp, host_ready, hold_req, bus_hold_grant, dsp_ready;
    logic        pm_en, pm_we, seq_mem_en, seq_mem_we, seq_owns_im, im_cyc, im_we;
    logic        im_refresh, ic, se, we;
    logic [31:0] hrdata, im_wdata, wd;
    logic [15:0] host_rdata, dsp_rdata, pm_wdata, pm_rdata, seq_mem_wdata;
    logic [14:0] pm_addr, seq_mem_addr, sa;
    logic [3:0]  im_be, ib;
    logic [29:0] im_addr, ia;
    int          bad_count = 0, checked = 0, n, w0, w1, cnt;

    hdma_arbiter dut (.*);
    hdma_dsp_model #(.DELAY(2)) u_dsp (.*);
    assign hready = hreadyout;
    always #20 hclk = ~hclk;

    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic guard(input int k);
        if (k >= 60) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 60);
        guard(n);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 60);
        guard(n);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic hpm(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output int k);
        host_cyc   <= 1'b1;
        host_wr    <= w;
        host_addr  <= a;
        host_wdata <= d;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (host_ready !== 1'b1 && k < 60);
        guard(k);
        repeat (3) @(posedge hclk);
        if (!w) begin
            chk(host_rdata, d);
        end
        host_cyc <= 1'b0;
        @(posedge hclk);
        chk(hold_req, 1'b0);
    endtask

    task automatic him(input logic e);
        host_cyc  <= 1'b1;
        host_wr   <= 1'b0;
        host_addr <= 16'h0124;
        @(posedge hclk);
        chk(host_ready, 1'b1);
        @(posedge hclk);
        chk(im_cyc, e);
        host_cyc <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic href(input logic e);
        host_refresh <= 1'b1;
        @(posedge hclk);
        host_refresh <= 1'b0;
        @(posedge hclk);
        chk(im_refresh, e);
    endtask

    task automatic dcyc(input logic w, input logic [15:0] a, input logic [15:0] d);
        dsp_cyc   <= 1'b1;
        dsp_wr    <= w;
        dsp_addr  <= a;
        dsp_wdata <= d;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (dsp_ready !== 1'b1 && n < 60);
        guard(n);
        ic = im_cyc;
        ia = im_addr;
        ib = im_be;
        se = seq_mem_en;
        sa = seq_mem_addr;
        we = im_we;
        wd = im_wdata;
        dsp_cyc <= 1'b0;
        @(posedge hclk);
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4), 32'h0);
        end
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0);
        wr(`HDMA_OFF_HOST_CTRL, 32'h1234_0050);
        rd(`HDMA_OFF_HOST_CTRL, 32'h0000_0050);
        wr(`HDMA_OFF_HOST_CTRL, 32'h0);
        hpm(1'b1, 16'h0003, 16'hbeef, w0);
        hpm(1'b0, 16'h0003, 16'hbeef, w0);
        chk(w0 > 1, 1'b1);
        rpt_cycles <= 8'd6;
        hpm(1'b0, 16'h0003, 16'hbeef, w1);
        chk(w1 - w0, 6);
        rpt_cycles <= 8'd0;
        for (int i = 0; i < 4; i++) begin
            wr(`HDMA_OFF_HOST_CTRL, 32'h40 | (32'(i / 2) << 4));
            wr(`HDMA_OFF_PROC_ARB, 32'(i % 2) << 4);
            him(i == 2);
        end
        wr(`HDMA_OFF_HOST_CTRL, 32'h50);
        wr(`HDMA_OFF_PROC_ARB, 32'h0);
        href(1'b0);
        wr(`HDMA_OFF_VERT_CTRL, 32'h1);
        href(1'b1);
        wr(`HDMA_OFF_HOST_CTRL, 32'h10);
        href(1'b1);
        wr(`HDMA_OFF_HOST_CTRL, 32'h50);
        video_active <= 1'b1;
        him(1'b0);
        chk(seq_owns_im, 1'b1);
        hblank <= 1'b1;
        cnt = 0;
        repeat (12) begin
            @(posedge hclk);
            cnt += int'(im_refresh === 1'b1);
        end
        chk(cnt, 5);
        hblank <= 1'b0;
        video_active <= 1'b0;
        wr(`HDMA_OFF_HOST_CTRL, 32'h40);
        wr(`HDMA_OFF_PROC_ARB, 32'h10);
        wr(`HDMA_OFF_PROC_CTRL, 32'h8000);
        dcyc(1'b0, 16'h0100, 16'h0);
        chk(ic, 1'b0);
        wr(`HDMA_OFF_MOR_PROC, 32'h5);
        wr(`HDMA_OFF_MOR_HOST, 32'h7);
        rd(`HDMA_OFF_MOR_PROC, 32'h5);
        dcyc(1'b0, 16'hc004, 16'h0);
        chk(n, 2);
        chk(ia, {16'h0005 + 16'h0003, 14'h0004});
        dcyc(1'b0, 16'h0102, 16'h0);
        chk(ic, 1'b1);
        chk(dsp_rdata, 16'h4433);
        chk(we, 1'b0);
        wr(`HDMA_OFF_PROC_MODE, 32'h1);
        dcyc(1'b0, 16'h0102, 16'h0);
        chk(dsp_rdata, 16'h0033);
        dcyc(1'b1, 16'h0101, 16'h00a5);
        chk(ib, 4'b0010);
        chk(we, 1'b1);
        chk(wd, 32'ha5a5_a5a5);
        wr(`HDMA_OFF_STATUS, 32'h8);
        rd(`HDMA_OFF_STATUS, 32'h0);
        repeat (400) @(posedge hclk);
        rd(`HDMA_OFF_STATUS, 32'h8);
        wr(`HDMA_OFF_PROC_CTRL, 32'h0);
        dcyc(1'b0, 16'h8010, 16'h0);
        chk(se, 1'b1);
        chk(sa, 15'h0010);
        report_and_stop();
    end
endmodule
`default_nettype wire
